/* cell_side_model.sv */
// behavioural cell comparators, charger and load seen by the arbiter
`default_nettype none
module cell_side_model (
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic [4:0] want, // overcharge, overdischarge, overcurrent, short, charger
    output logic ovc_pin, // overcharge comparator level
    output logic ovd_pin, // overdischarge comparator level
    output logic ocur_pin, // overcurrent comparator level
    output logic short_pin, // short comparator level
    output logic xchg_pin // excessive-charger comparator level
);
    timeunit 1ns;
    timeprecision 1ns;
    // comparators settle one edge after the analog condition changes, never mid-cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {ovc_pin, ovd_pin, ocur_pin, short_pin, xchg_pin} <= 5'h00;
        end else begin
            {ovc_pin, ovd_pin, ocur_pin, short_pin, xchg_pin} <= want;
        end
    end
endmodule
`default_nettype wire

/* delay_filter.sv */
// confirms a condition after it has held for a counted delay
`include "fault_arbiter_params.svh"
`default_nettype none
module delay_filter (
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic clk_en, // freezes state when low
    delay_if.flt d // condition, run gate, limit, confirmed
);
    import fault_arbiter_pkg::*;
    cnt_t cnt_reg;
    logic done_reg;

    // count while the condition holds and the arbiter lets it run; drop out otherwise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 16'h0000;
            done_reg <= 1'b0;
        end else if (clk_en) begin
            if (!d.cond || !d.run) begin
                cnt_reg <= 16'h0000;
                done_reg <= 1'b0;
            end else if (cnt_reg >= d.limit) begin
                done_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end
    assign d.done = done_reg;
endmodule
`default_nettype wire

/* delay_if.sv */
// carrier between arbiter and one detection delay filter
`default_nettype none
interface delay_if;
    logic cond;
    logic run;
    fault_arbiter_pkg::cnt_t limit;
    logic done;
    modport arb (output cond, output run, output limit, input done);
    modport flt (input cond, input run, input limit, output done);
endinterface
`default_nettype wire

/* fault_arbiter.sv */
// overlap arbiter for overcharge, overdischarge, overcurrent, short and charger faults
`include "fault_arbiter_params.svh"
`default_nettype none
module fault_arbiter #(
    parameter int CNT_W = `CNT_WIDTH // delay counter width
) (
    input wire logic clk, // internal oscillator clock
    input wire logic reset_n, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic ovc_pin, // overcharge comparator
    input wire logic ovd_pin, // overdischarge comparator
    input wire logic ocur_pin, // overcurrent comparator
    input wire logic short_pin, // short-circuit comparator
    input wire logic xchg_pin, // excessive-charger comparator
    input wire logic fast_pin, // delay shorten select
    output logic charge_gate, // high lets charging through
    output logic discharge_gate, // high lets discharging through
    output var fault_arbiter_pkg::pull_e sense_pull, // sense-node pull routing
    output logic standby // low-power standby
);
    import fault_arbiter_pkg::*;

    // two-stage synchronisers for all comparator pins
    logic [5:0] pin_s1_reg, pin_s2_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_reg <= 6'h00;
            pin_s2_reg <= 6'h00;
        end else if (clk_en) begin
            pin_s1_reg <= {fast_pin, xchg_pin, short_pin, ocur_pin, ovd_pin, ovc_pin};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    logic ovc_c, ovd_c, ocur_c, short_c, xchg_c, fast_c;
    assign {fast_c, xchg_c, short_c, ocur_c, ovd_c, ovc_c} = pin_s2_reg;

    // shortened delays divide by a power of two; never below one cycle
    function automatic cnt_t scale(input cnt_t full, input logic fast);
        cnt_t s;
        s = fast ? (full >> `FAST_SHIFT) : full;
        scale = (s == 16'h0000) ? 16'h0001 : s;
    endfunction

    // confirmed detection state
    logic ovc_reg, ovd_reg, ocur_reg, short_reg, xchg_reg;
    logic ovd_after_ovc_reg, ocur_first_reg;
    logic [4:0] done_w;

    // five filters, one per detection
    delay_if dl [5] ();
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flt
            delay_filter u_flt (
                .clk(clk),
                .reset_n(reset_n),
                .clk_en(clk_en),
                .d(dl[gi])
            );
            assign done_w[gi] = dl[gi].done;
        end
    endgenerate

    // overcharge: runs regardless of overcurrent; confirm after counted delay
    assign dl[0].cond = ovc_c;
    assign dl[0].run = !ovc_reg;
    assign dl[0].limit = scale(`OVC_DELAY_CNT, fast_c);
    // overdischarge: held at zero while overcharge pends, restarts from zero once it confirms
    assign dl[1].cond = ovd_c;
    assign dl[1].run = !ovd_reg && !(ovc_c && !ovc_reg);
    assign dl[1].limit = scale(`OVD_DELAY_CNT, fast_c);
    // overcurrent: aborted when an overcharge or overdischarge condition came first
    assign dl[2].cond = ocur_c;
    assign dl[2].run = !ocur_reg && !((ovc_c || ovd_c) && !ocur_first_reg);
    assign dl[2].limit = scale(`OCUR_DELAY_CNT, fast_c);
    // short: fixed delay, nothing blocks it
    assign dl[3].cond = short_c;
    assign dl[3].run = !short_reg;
    assign dl[3].limit = `SHORT_DELAY_CNT;
    // excessive charger: only with discharge gate high and no discharge-side fault
    assign dl[4].cond = xchg_c;
    assign dl[4].run = !xchg_reg && discharge_gate && !ovd_reg && !ocur_reg && !short_reg;
    assign dl[4].limit = scale(`XCHG_DELAY_CNT, fast_c);

    // overcharge state: set on confirm, clear when the condition goes away
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ovc_reg <= 1'b0;
        end else if (clk_en) begin
            if (done_w[0]) begin
                ovc_reg <= 1'b1;
            end else if (!ovc_c) begin
                ovc_reg <= 1'b0;
            end
        end
    end

    // overdischarge state; remembers whether overcharge was already in force
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ovd_reg <= 1'b0;
            ovd_after_ovc_reg <= 1'b0;
        end else if (clk_en) begin
            if (done_w[1] && !ovd_reg) begin
                ovd_reg <= 1'b1;
                ovd_after_ovc_reg <= ovc_reg;
            end else if (!ovd_c) begin
                ovd_reg <= 1'b0;
                ovd_after_ovc_reg <= 1'b0;
            end
        end
    end

    // overcurrent and short states; first-arrival flag decides abort and pull
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ocur_reg <= 1'b0;
            short_reg <= 1'b0;
            ocur_first_reg <= 1'b0;
        end else if (clk_en) begin
            ocur_first_reg <= ocur_c && (ocur_first_reg || !(ovc_c || ovd_c));
            if (done_w[2]) begin
                ocur_reg <= 1'b1;
            end else if (!ocur_c) begin
                ocur_reg <= 1'b0;
            end
            if (done_w[3]) begin
                short_reg <= 1'b1;
            end else if (!short_c) begin
                short_reg <= 1'b0;
            end
        end
    end

    // excessive charger state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xchg_reg <= 1'b0;
        end else if (clk_en) begin
            if (done_w[4]) begin
                xchg_reg <= 1'b1;
            end else if (!xchg_c) begin
                xchg_reg <= 1'b0;
            end
        end
    end

    // output decisions, re-evaluated every clock
    logic charge_next, discharge_next, standby_next;
    pull_e pull_next;
    always_comb begin
        charge_next = !(ovc_reg || xchg_reg);
        discharge_next = !(ovd_reg || ocur_reg || short_reg);
        standby_next = ovd_reg && !ovd_after_ovc_reg && !ovc_reg;
        if (ovd_reg) begin
            pull_next = PULL_VDD;
        end else if (ovc_reg && !ocur_first_reg) begin
            pull_next = PULL_NONE;
        end else if (ocur_reg || short_reg) begin
            pull_next = PULL_VSS;
        end else begin
            pull_next = PULL_NONE;
        end
    end

    // registered outputs; priorities settle in one clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            charge_gate <= 1'b1;
            discharge_gate <= 1'b1;
            sense_pull <= PULL_NONE;
            standby <= 1'b0;
        end else if (clk_en) begin
            charge_gate <= charge_next;
            discharge_gate <= discharge_next;
            sense_pull <= pull_next;
            standby <= standby_next;
        end
    end

    // assertions on the charge gate and the overcharge outcome
    a_ovc_gate_low: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovc_reg |=> !charge_gate)
        else $error("charge gate high during overcharge");

    a_cgate_free: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !ovc_reg && !xchg_reg |=> charge_gate)
        else $error("charge gate low with no charge-side fault");

    a_ovc_no_standby: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovc_reg |=> !standby)
        else $error("standby during overcharge");

    a_ovc_first_keeps: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovc_reg && ovd_reg |=> !charge_gate && !standby)
        else $error("overcharge outcome lost on overdischarge");

    a_ovc_parallel: assert property (@(posedge clk) disable iff (!reset_n)
        ovc_c && ocur_c && !ovc_reg |-> dl[0].run)
        else $error("overcharge delay stopped by overcurrent");

    a_ovc_pull_none: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovc_reg && !ovd_reg && !ocur_first_reg |=> sense_pull == PULL_NONE)
        else $error("pull not released on overcharge");

    // assertions on overdischarge, standby and the supply pull
    a_ovd_pull_vdd: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovd_reg |=> sense_pull == PULL_VDD)
        else $error("no supply pull on overdischarge");

    a_ovd_dgate_low: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovd_reg |=> !discharge_gate)
        else $error("discharge gate high in overdischarge");

    a_stby_needs_ovd: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !ovd_reg |=> !standby)
        else $error("standby without overdischarge");

    a_ovd_ovc_nostby: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovd_after_ovc_reg |=> !standby)
        else $error("standby after overcharge-first overdischarge");

    a_ovd_first_stby: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovd_reg && !ovd_after_ovc_reg && !ovc_reg |=> standby)
        else $error("no standby on overdischarge");

    a_ocur_ovd_stby: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovd_reg && ocur_first_reg && !ovc_reg && !ovd_after_ovc_reg |=> standby && sense_pull == PULL_VDD)
        else $error("overdischarge after overcurrent not handled");

    a_ovd_pause: assert property (@(posedge clk) disable iff (!reset_n)
        ovc_c && !ovc_reg |-> !dl[1].run)
        else $error("overdischarge delay ran during pending overcharge");

    a_ovd_resume: assert property (@(posedge clk) disable iff (!reset_n)
        ovc_reg && ovd_c && !ovd_reg |-> dl[1].run)
        else $error("overdischarge delay not resumed");

    // assertions on overcurrent and short
    a_ocur_no_stby: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && (ocur_reg || short_reg) && !ovd_reg |=> !standby && !discharge_gate)
        else $error("overcurrent misbehaved");

    a_dgate_free: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !ovd_reg && !ocur_reg && !short_reg |=> discharge_gate)
        else $error("discharge gate low with no discharge-side fault");

    a_ocur_abort: assert property (@(posedge clk) disable iff (!reset_n)
        (ovc_c || ovd_c) && !ocur_first_reg |-> !dl[2].run)
        else $error("overcurrent not aborted");

    a_ocur_abort_ovd: assert property (@(posedge clk) disable iff (!reset_n)
        ovd_c && !ocur_first_reg |-> !dl[2].run)
        else $error("overcurrent not aborted by overdischarge");

    a_ocur_first_flag: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ocur_c && !ovc_c && !ovd_c |=> ocur_first_reg)
        else $error("overcurrent arrival not recorded");

    a_ocur_pull_vss: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ocur_reg && !ovd_reg && !ovc_reg |=> sense_pull == PULL_VSS)
        else $error("no ground pull on overcurrent");

    a_short_free: assert property (@(posedge clk) disable iff (!reset_n)
        !short_reg |-> dl[3].run)
        else $error("short detection blocked");

    a_short_fixed: assert property (@(posedge clk) disable iff (!reset_n)
        dl[3].limit == `SHORT_DELAY_CNT)
        else $error("short delay was shortened");

    // assertions on the charger filter, delay select and freeze
    a_xchg_blocked: assert property (@(posedge clk) disable iff (!reset_n)
        !discharge_gate |-> !dl[4].run)
        else $error("charger delay ran with gate low");

    a_xchg_suppress: assert property (@(posedge clk) disable iff (!reset_n)
        ovd_reg || ocur_reg || short_reg |-> !dl[4].run)
        else $error("charger delay ran during discharge fault");

    a_fast_limit: assert property (@(posedge clk) disable iff (!reset_n)
        fast_c |-> dl[0].limit == (`OVC_DELAY_CNT >> `FAST_SHIFT))
        else $error("overcharge delay not shortened");

    a_normal_limit: assert property (@(posedge clk) disable iff (!reset_n)
        !fast_c |-> dl[0].limit == `OVC_DELAY_CNT)
        else $error("overcharge delay shortened unasked");

    // a frozen clock enable must hold both gates and standby where they were
    a_frozen: assert property (@(posedge clk) disable iff (!reset_n)
        !clk_en |=> $stable(charge_gate) && $stable(discharge_gate) && $stable(standby))
        else $error("outputs moved while clock enable was low");

    // covers for the main scenarios
    c_ovc: cover property (@(posedge clk) disable iff (!reset_n) ovc_reg && !charge_gate);
    c_ovd_stby: cover property (@(posedge clk) disable iff (!reset_n) standby);
    c_ocur_then_ovd: cover property (@(posedge clk) disable iff (!reset_n) ocur_reg ##[1:50] ovd_reg);
    c_xchg: cover property (@(posedge clk) disable iff (!reset_n) xchg_reg);
    c_ovd_after_ovc: cover property (@(posedge clk) disable iff (!reset_n) ovd_reg && ovd_after_ovc_reg);
endmodule
`default_nettype wire

/* fault_arbiter_params.svh */
// timing counts, delay shift and counter width for the battery fault overlap arbiter
`ifndef FAULT_ARBITER_PARAMS_SVH
`define FAULT_ARBITER_PARAMS_SVH

`define CLK_PERIOD_NS 10
`define OVC_DELAY_CNT 16'h0100
`define OVD_DELAY_CNT 16'h0080
`define OCUR_DELAY_CNT 16'h0040
`define SHORT_DELAY_CNT 16'h0004
`define XCHG_DELAY_CNT 16'h0080
`define REL_DELAY_CNT 16'h0020
`define FAST_SHIFT 4
`define CNT_WIDTH 16

`endif

/* fault_arbiter_pkg.sv */
// types shared by the fault arbiter modules
`default_nettype none
package fault_arbiter_pkg;
    typedef enum logic [1:0] {
        PULL_NONE = 2'b00,
        PULL_VDD = 2'b01,
        PULL_VSS = 2'b11
    } pull_e;
    typedef logic [15:0] cnt_t;
endpackage
`default_nettype wire

/* testbench.sv */
// self-checking bench for the fault overlap arbiter
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import fault_arbiter_pkg::*;
    localparam logic [4:0] OVC = 5'h10;
    localparam logic [4:0] OVD = 5'h08;
    localparam logic [4:0] OCR = 5'h04;
    localparam logic [4:0] SHT = 5'h02;
    localparam logic [4:0] XCH = 5'h01;
    logic clk, reset_n, fast, en, ovc, ovd, ocur, shrt, xchg, charge_gate, discharge_gate, standby;
    logic [4:0] want;
    pull_e sense_pull;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    cell_side_model side (.clk(clk), .reset_n(reset_n), .want(want), .ovc_pin(ovc), .ovd_pin(ovd),
        .ocur_pin(ocur), .short_pin(shrt), .xchg_pin(xchg));
    fault_arbiter uut (.clk(clk), .reset_n(reset_n), .clk_en(en), .ovc_pin(ovc), .ovd_pin(ovd),
        .ocur_pin(ocur), .short_pin(shrt), .xchg_pin(xchg), .fast_pin(fast), .charge_gate(charge_gate),
        .discharge_gate(discharge_gate), .sense_pull(sense_pull), .standby(standby));
    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // expected port state packed as charge, discharge, pull, standby
    function automatic logic [4:0] ex(input logic cg, input logic dg, input pull_e p, input logic sb);
        return {cg, dg, p, sb};
    endfunction
    task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // apply conditions at a rising edge, hold them n cycles, then sample settled outputs
    task automatic go(input logic [4:0] w, input int n, input logic f = 1'b0);
        @(posedge clk);
        want <= w;
        fast <= f;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard: the whole sequence needs well under 6000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            err_count++;
            wrap_up();
        end
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        fast = 1'b0;
        en = 1'b1;
        want = 5'h00;
        void'($urandom(32'hAEFE));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        go(5'h00, 2);
        chk({charge_gate, discharge_gate, sense_pull, standby}, ex(1, 1, PULL_NONE, 0));
        go(OVD, 200);
        chk({charge_gate, discharge_gate, sense_pull, standby}, ex(1, 0, PULL_VDD, 1));
        go(5'h00, 20);
        go(OCR, 120);
        chk({charge_gate, discharge_gate, sense_pull, standby}, ex(1, 0, PULL_VSS, 0));
        go(OCR | OVD, 200);
        chk({charge_gate, discharge_gate, sense_pull, standby}, ex(1, 0, PULL_VDD, 1));
        go(5'h00, 20);
        go(OVC, 30);
        go(OVC | SHT, 20);
        chk({2'b00, charge_gate, discharge_gate, standby}, 5'h04);
        go(OVC, 250);
        chk({charge_gate, discharge_gate, sense_pull, standby}, ex(0, 1, PULL_NONE, 0));
        go(5'h00, 20);
        go(OVC, 300);
        go(OVC | OVD, 200);
        chk({charge_gate, discharge_gate, sense_pull, standby}, ex(0, 0, PULL_VDD, 0));
        go(5'h00, 20);
        go(OVD, 50);
        go(OVD | OVC, 120);
        chk({3'h0, charge_gate, discharge_gate}, 5'h03);
        go(OVD | OVC, 300);
        chk({charge_gate, discharge_gate, sense_pull, standby}, ex(0, 0, PULL_VDD, 0));
        go(5'h00, 20);
        go(OVC, 20);
        go(OVC | OCR, 150);
        chk({3'h0, charge_gate, discharge_gate}, 5'h03);
        go(OVC | OCR, 150);
        chk({charge_gate, discharge_gate, sense_pull, standby}, ex(0, 1, PULL_NONE, 0));
        go(5'h00, 20);
        // charger count may only start once the discharge gate is back up
        go(OCR, 100);
        go(OCR | XCH, 200);
        chk({4'h0, charge_gate}, 5'h01);
        go(XCH, 50);
        chk({4'h0, charge_gate}, 5'h01);
        go(XCH, 150);
        chk({4'h0, charge_gate}, 5'h00);
        go(5'h00, 20);
        go(OVC, 40, 1'b1);
        chk({4'h0, charge_gate}, 5'h00);
        go(5'h00, 20);
        // a low clock enable freezes the overcharge count; it completes once released
        go(OVC, 20);
        @(posedge clk);
        en <= 1'b0;
        repeat (400) @(posedge clk);
        #1;
        chk({4'h0, charge_gate}, 5'h01);
        @(posedge clk);
        en <= 1'b1;
        go(OVC, 300);
        chk({4'h0, charge_gate}, 5'h00);
        go(5'h00, 20);
        // random short glitches must never confirm a fault
        repeat (6) begin
            go(($urandom_range(1) != 0) ? OCR : OVD, $urandom_range(40, 5));
            go(5'h00, 10 + $urandom_range(10));
            chk({charge_gate, discharge_gate, sense_pull, standby}, ex(1, 1, PULL_NONE, 0));
        end
        wrap_up();
    end
endmodule
`default_nettype wire
